// >>> inc/lane_err_pkg.sv
// Register map, fields and reset values of the lane error monitor
`default_nettype none
package lane_err_pkg;
    localparam int unsigned ADDR_W    = 12;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned LANES     = 8;
    localparam int unsigned LANE_W    = 3;
    localparam int unsigned CNT_W     = 8;
    localparam int unsigned ERR_TYPES = 3;

    // Register offsets
    localparam logic [11:0] DENSITY_CFG_ADDR  = 12'h45a;
    localparam logic [11:0] RESERVED_ONE_ADDR = 12'h45b;
    localparam logic [11:0] RESERVED_TWO_ADDR = 12'h45c;
    localparam logic [11:0] CHECKSUM_ADDR     = 12'h45d;
    localparam logic [11:0] COUNT_SELECT_ADDR = 12'h46b;
    localparam logic [11:0] DESKEW_ADDR       = 12'h46c;
    localparam logic [11:0] DISPARITY_ADDR    = 12'h46d;
    localparam logic [11:0] INVALID_SYM_ADDR  = 12'h46e;

    // Field positions
    localparam int unsigned HIGH_DENSITY_BIT = 7;
    localparam int unsigned CWPF_MSB         = 4;
    localparam int unsigned LANE_SEL_LSB     = 4;
    localparam int unsigned LANE_SEL_MSB     = 6;
    localparam int unsigned TYPE_SEL_MSB     = 1;
    localparam int unsigned IRQ_CLEAR_BIT    = 7;
    localparam int unsigned CNT_DISABLE_BIT  = 6;
    localparam int unsigned CNT_CLEAR_BIT    = 5;
    localparam int unsigned LANE_ADDR_MSB    = 2;

    // Reset values
    localparam logic       HIGH_DENSITY_RST = 1'h1;
    localparam logic [4:0] CWPF_RST         = 5'h00;
    localparam logic [7:0] RESERVED_RST     = 8'h00;
    localparam logic [7:0] CHECKSUM_RST     = 8'h45;
    localparam logic [7:0] DESKEW_RST       = 8'h0f;

    // Counter type codes
    typedef enum logic [1:0] {
        CNT_DISPARITY   = 2'b00,
        CNT_INVALID_SYM = 2'b01,
        CNT_UNEXPECTED  = 2'b10
    } counter_type_type;
endpackage
`default_nettype wire

// >>> hw/lane_err_monitor.sv
// Lane error counters, threshold flags and link configuration registers
`timescale 1ns/100ps
`default_nettype none
module lane_err_monitor (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wr_data,
    output logic      [7:0]  reg_rd_data,
    output logic             reg_rd_valid,
    input  wire logic [7:0]  disparity_err,
    input  wire logic [7:0]  invalid_symbol_err,
    input  wire logic [7:0]  unexpected_ctrl_err,
    input  wire logic [7:0]  error_threshold,
    input  wire logic        checksum_load,
    input  wire logic [7:0]  checksum_calc,
    output logic             high_density_flag,
    output logic      [4:0]  control_words_per_frame,
    output logic      [7:0]  reserved_field_one,
    output logic      [7:0]  reserved_field_two,
    output logic      [7:0]  lane_zero_checksum_value,
    output logic      [7:0]  lane_deskew_enable,
    output logic      [7:0]  disparity_irq,
    output logic      [7:0]  invalid_symbol_irq
);

    localparam int unsigned NL = lane_err_pkg::LANES;
    localparam int unsigned NT = lane_err_pkg::ERR_TYPES;

    // One-hot lane from a three-bit lane address
    function automatic logic [7:0] lane_onehot(input logic [2:0] lane);
        lane_onehot = 8'h01 << lane;
    endfunction

    // Address compare shared by every register write
    function automatic logic write_hit(input logic en, input logic [11:0] addr, input logic [11:0] target);
        write_hit = en && addr == target;
    endfunction

    // Register write decode
    logic       wr_density;
    logic       wr_res_one;
    logic       wr_res_two;
    logic       wr_checksum;
    logic       wr_select;
    logic       wr_deskew;
    logic       wr_disparity;
    logic       wr_invalid;

    assign wr_density   = write_hit(reg_wr_en, reg_addr, lane_err_pkg::DENSITY_CFG_ADDR);
    assign wr_res_one   = write_hit(reg_wr_en, reg_addr, lane_err_pkg::RESERVED_ONE_ADDR);
    assign wr_res_two   = write_hit(reg_wr_en, reg_addr, lane_err_pkg::RESERVED_TWO_ADDR);
    assign wr_checksum  = write_hit(reg_wr_en, reg_addr, lane_err_pkg::CHECKSUM_ADDR);
    assign wr_select    = write_hit(reg_wr_en, reg_addr, lane_err_pkg::COUNT_SELECT_ADDR);
    assign wr_deskew    = write_hit(reg_wr_en, reg_addr, lane_err_pkg::DESKEW_ADDR);
    assign wr_disparity = write_hit(reg_wr_en, reg_addr, lane_err_pkg::DISPARITY_ADDR);
    assign wr_invalid   = write_hit(reg_wr_en, reg_addr, lane_err_pkg::INVALID_SYM_ADDR);

    // Control write fields, valid only during the write
    logic       disparity_irq_clear;
    logic       disparity_counter_disable;
    logic       disparity_counter_clear;
    logic [2:0] disparity_lane_address;
    logic       invalid_symbol_irq_clear;
    logic       invalid_symbol_counter_disable;
    logic       invalid_symbol_counter_clear;
    logic [2:0] invalid_symbol_lane_address;

    assign disparity_irq_clear            = wr_disparity && reg_wr_data[lane_err_pkg::IRQ_CLEAR_BIT];
    assign disparity_counter_disable      = wr_disparity && reg_wr_data[lane_err_pkg::CNT_DISABLE_BIT];
    assign disparity_counter_clear        = wr_disparity && reg_wr_data[lane_err_pkg::CNT_CLEAR_BIT];
    assign disparity_lane_address         = reg_wr_data[lane_err_pkg::LANE_ADDR_MSB:0];
    assign invalid_symbol_irq_clear       = wr_invalid && reg_wr_data[lane_err_pkg::IRQ_CLEAR_BIT];
    assign invalid_symbol_counter_disable = wr_invalid && reg_wr_data[lane_err_pkg::CNT_DISABLE_BIT];
    assign invalid_symbol_counter_clear   = wr_invalid && reg_wr_data[lane_err_pkg::CNT_CLEAR_BIT];
    assign invalid_symbol_lane_address    = reg_wr_data[lane_err_pkg::LANE_ADDR_MSB:0];

    // Per-type strobes, decoded only in the write cycle
    logic [7:0] irq_clear   [NT];
    logic [7:0] cnt_clear   [NT];
    logic [7:0] cnt_disable [NT];
    logic [7:0] err_in      [NT];

    always_comb begin
        for (int t = 0; t < NT; t++) begin
            irq_clear[t]   = 8'h00;
            cnt_clear[t]   = 8'h00;
            cnt_disable[t] = 8'h00;
        end
        if (disparity_irq_clear) begin
            irq_clear[0] = lane_onehot(disparity_lane_address);
        end
        if (disparity_counter_disable) begin
            cnt_disable[0] = lane_onehot(disparity_lane_address);
        end
        if (disparity_counter_clear) begin
            cnt_clear[0] = lane_onehot(disparity_lane_address);
        end
        if (invalid_symbol_irq_clear) begin
            irq_clear[1] = lane_onehot(invalid_symbol_lane_address);
        end
        if (invalid_symbol_counter_disable) begin
            cnt_disable[1] = lane_onehot(invalid_symbol_lane_address);
        end
        if (invalid_symbol_counter_clear) begin
            cnt_clear[1] = lane_onehot(invalid_symbol_lane_address);
        end
    end

    assign err_in[0] = disparity_err;
    assign err_in[1] = invalid_symbol_err;
    assign err_in[2] = unexpected_ctrl_err;

    logic [7:0] count_q  [NT][NL];
    // Status and interrupt exist for the two controlled types only
    logic [7:0] flag_q   [2];
    logic [7:0] irq_q    [2];
    logic [7:0] off_q    [NT];

    genvar gt;
    genvar gl;
    generate
        for (gt = 0; gt < NT; gt++) begin : g_type
            for (gl = 0; gl < NL; gl++) begin : g_lane
                logic       counting;
                logic [7:0] count_d;

                // Clear reopens the lane; a same-cycle error counts
                assign counting = err_in[gt][gl] && (cnt_clear[gt][gl] || !off_q[gt][gl]);

                // count and saturate at all ones
                always_comb begin
                    count_d = count_q[gt][gl];
                    if (cnt_clear[gt][gl]) begin
                        count_d = counting ? 8'h01 : 8'h00;
                    end else if (counting && count_q[gt][gl] != 8'hff) begin
                        count_d = count_q[gt][gl] + 8'h01;
                    end
                end

                always_ff @(posedge clk or negedge rstn) begin
                    if (!rstn) begin
                        count_q[gt][gl] <= 8'h00;
                    end else begin
                        count_q[gt][gl] <= count_d;
                    end
                end

                // Disable holds until the counter is cleared; a disable in the same write wins
                always_ff @(posedge clk or negedge rstn) begin
                    if (!rstn) begin
                        off_q[gt][gl] <= 1'b0;
                    end else if (cnt_disable[gt][gl]) begin
                        off_q[gt][gl] <= 1'b1;
                    end else if (cnt_clear[gt][gl]) begin
                        off_q[gt][gl] <= 1'b0;
                    end
                end

                // Unexpected-control lanes have no status register here
                if (gt < 2) begin : g_status
                    logic reached;

                    assign reached = error_threshold != 8'h00 && count_d >= error_threshold;

                    always_ff @(posedge clk or negedge rstn) begin
                        if (!rstn) begin
                            flag_q[gt][gl] <= 1'b0;
                        end else begin
                            flag_q[gt][gl] <= (flag_q[gt][gl] && !cnt_clear[gt][gl]) || reached;
                        end
                    end

                    always_ff @(posedge clk or negedge rstn) begin
                        if (!rstn) begin
                            irq_q[gt][gl] <= 1'b0;
                        end else begin
                            irq_q[gt][gl] <= (irq_q[gt][gl] && !irq_clear[gt][gl])
                                             || (reached && !flag_q[gt][gl]);
                        end
                    end
                end
            end
        end
    endgenerate

    assign disparity_irq      = irq_q[0];
    assign invalid_symbol_irq = irq_q[1];

    // Per-type views under their field names
    logic [7:0] disparity_error_count      [NL];
    logic [7:0] invalid_symbol_error_count [NL];
    logic [7:0] unexpected_ctrl_char_count [NL];
    logic [7:0] disparity_error_flag;
    logic [7:0] invalid_symbol_flag;

    assign disparity_error_count      = count_q[0];
    assign invalid_symbol_error_count = count_q[1];
    assign unexpected_ctrl_char_count = count_q[2];
    assign disparity_error_flag       = flag_q[0];
    assign invalid_symbol_flag        = flag_q[1];

    // format fields, peer keeps them legal
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            high_density_flag       <= lane_err_pkg::HIGH_DENSITY_RST;
            control_words_per_frame <= lane_err_pkg::CWPF_RST;
        end else if (wr_density) begin
            high_density_flag       <= reg_wr_data[lane_err_pkg::HIGH_DENSITY_BIT];
            control_words_per_frame <= reg_wr_data[lane_err_pkg::CWPF_MSB:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reserved_field_one <= lane_err_pkg::RESERVED_RST;
        end else if (wr_res_one) begin
            reserved_field_one <= reg_wr_data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reserved_field_two <= lane_err_pkg::RESERVED_RST;
        end else if (wr_res_two) begin
            reserved_field_two <= reg_wr_data;
        end
    end

    // checksum, software write wins over load
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lane_zero_checksum_value <= lane_err_pkg::CHECKSUM_RST;
        end else if (wr_checksum) begin
            lane_zero_checksum_value <= reg_wr_data;
        end else if (checksum_load) begin
            lane_zero_checksum_value <= checksum_calc;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lane_deskew_enable <= lane_err_pkg::DESKEW_RST;
        end else if (wr_deskew) begin
            lane_deskew_enable <= reg_wr_data;
        end
    end

    logic [2:0] counter_lane_select;
    logic [1:0] counter_type_select;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            counter_lane_select <= 3'h0;
            counter_type_select <= 2'h0;
        end else if (wr_select) begin
            counter_lane_select <= reg_wr_data[lane_err_pkg::LANE_SEL_MSB:lane_err_pkg::LANE_SEL_LSB];
            counter_type_select <= reg_wr_data[lane_err_pkg::TYPE_SEL_MSB:0];
        end
    end

    logic [7:0] error_count_value;
    logic [7:0] rd_d;

    always_comb begin
        unique case (counter_type_select)
            lane_err_pkg::CNT_DISPARITY:   error_count_value = disparity_error_count[counter_lane_select];
            lane_err_pkg::CNT_INVALID_SYM: error_count_value = invalid_symbol_error_count[counter_lane_select];
            lane_err_pkg::CNT_UNEXPECTED:  error_count_value = unexpected_ctrl_char_count[counter_lane_select];
            default:                       error_count_value = 8'h00;
        endcase
    end

    always_comb begin
        unique case (reg_addr)
            lane_err_pkg::DENSITY_CFG_ADDR:
                rd_d = {high_density_flag, 2'b00, control_words_per_frame};
            lane_err_pkg::RESERVED_ONE_ADDR: rd_d = reserved_field_one;
            lane_err_pkg::RESERVED_TWO_ADDR: rd_d = reserved_field_two;
            lane_err_pkg::CHECKSUM_ADDR:     rd_d = lane_zero_checksum_value;
            lane_err_pkg::COUNT_SELECT_ADDR: rd_d = error_count_value;
            lane_err_pkg::DESKEW_ADDR:       rd_d = lane_deskew_enable;
            lane_err_pkg::DISPARITY_ADDR:    rd_d = disparity_error_flag;
            lane_err_pkg::INVALID_SYM_ADDR:  rd_d = invalid_symbol_flag;
            // Unmapped addresses read zero
            default:                         rd_d = 8'h00;
        endcase
    end

    // Valid follows the read strobe by one cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
        end
    end

    // Read data from a flop, held until the next read
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rd_data <= 8'h00;
        end else if (reg_rd_en) begin
            reg_rd_data <= rd_d;
        end
    end

endmodule // lane_err_monitor
`default_nettype wire

// >>> verif/lane_err_checker.sv
// Port assertions for the lane error monitor
`timescale 1ns/100ps
`default_nettype none
module lane_err_checker (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        reg_wr_en,
    input wire logic        reg_rd_en,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0]  reg_wr_data,
    input wire logic        reg_rd_valid,
    input wire logic [7:0]  disparity_err,
    input wire logic [7:0]  invalid_symbol_err,
    input wire logic [7:0]  error_threshold,
    input wire logic        high_density_flag,
    input wire logic [4:0]  control_words_per_frame,
    input wire logic [7:0]  lane_zero_checksum_value,
    input wire logic [7:0]  lane_deskew_enable,
    input wire logic [7:0]  disparity_irq,
    input wire logic [7:0]  invalid_symbol_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_wr(logic [11:0] a);
        reg_wr_en && reg_addr == a;
    endsequence
    // No error or threshold move, so no set can win over the clear
    sequence s_clr(logic [11:0] a, logic [7:0] err);
        reg_wr_en && reg_addr == a && reg_wr_data[7] && err == 8'h00 && $stable(error_threshold);
    endsequence
    rd_answer_a: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read not answered next cycle");
    rd_quiet_a: assert property (!reg_rd_en |=> !reg_rd_valid)
        else $error("read valid without read");
    density_wr_a: assert property (s_wr(12'h45a) |=> high_density_flag == $past(reg_wr_data[7])
        && control_words_per_frame == $past(reg_wr_data[4:0])) else $error("density config not stored");
    checksum_wr_a: assert property (s_wr(12'h45d) |=> lane_zero_checksum_value == $past(reg_wr_data))
        else $error("checksum write lost");
    deskew_wr_a: assert property (s_wr(12'h46c) |=> lane_deskew_enable == $past(reg_wr_data))
        else $error("deskew write lost");
    disp_clear_a: assert property (s_clr(12'h46d, disparity_err) |=> !disparity_irq[$past(reg_wr_data[2:0])])
        else $error("disparity irq not cleared");
    nit_clear_a: assert property (s_clr(12'h46e, invalid_symbol_err)
        |=> !invalid_symbol_irq[$past(reg_wr_data[2:0])]) else $error("invalid symbol irq not cleared");
    irq_hold_a: assert property (!(reg_wr_en && reg_addr == 12'h46d)
        |=> (disparity_irq & $past(disparity_irq)) == $past(disparity_irq)) else $error("irq dropped by itself");
endmodule // lane_err_checker
bind lane_err_monitor lane_err_checker u_lane_err_checker (.clk(clk), .rstn(rstn), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_valid(reg_rd_valid),
    .disparity_err(disparity_err), .invalid_symbol_err(invalid_symbol_err), .error_threshold(error_threshold),
    .high_density_flag(high_density_flag), .control_words_per_frame(control_words_per_frame),
    .lane_zero_checksum_value(lane_zero_checksum_value), .lane_deskew_enable(lane_deskew_enable),
    .disparity_irq(disparity_irq), .invalid_symbol_irq(invalid_symbol_irq));
`default_nettype wire

// >>> verif/link_tx_model.sv
// Far-side transmitter model that injects per-lane character errors
`timescale 1ns/100ps
`default_nettype none
module link_tx_model (
    input  wire logic       clk,
    output var  logic [7:0] disparity_err,
    output var  logic [7:0] invalid_symbol_err,
    output var  logic [7:0] unexpected_ctrl_err
);
    initial begin
        disparity_err = 8'h00;
        invalid_symbol_err = 8'h00;
        unexpected_ctrl_err = 8'h00;
    end
    // Clean character between errors so each one counts once
    task automatic burst(input logic [1:0] kind, input logic [2:0] lane, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk) #1;
            case (kind)
                2'b00: disparity_err[lane] = 1'b1;
                2'b01: invalid_symbol_err[lane] = 1'b1;
                default: unexpected_ctrl_err[lane] = 1'b1;
            endcase
            @(posedge clk) #1;
            disparity_err = 8'h00;
            invalid_symbol_err = 8'h00;
            unexpected_ctrl_err = 8'h00;
        end
    endtask
endmodule // link_tx_model
`default_nettype wire

// >>> verif/lane_err_monitor_test.sv
// Self-checking bench for the lane error monitor
`timescale 1ns/100ps
`default_nettype none
module lane_err_monitor_test;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        reg_wr_en = 1'b0;
    logic        reg_rd_en = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0]  reg_wr_data = 8'h00;
    logic [7:0]  error_threshold = 8'h03;
    logic        checksum_load = 1'b0;
    logic [7:0]  checksum_calc = 8'h00;
    logic [7:0]  reg_rd_data, disparity_err, invalid_symbol_err, unexpected_ctrl_err;
    logic [7:0]  reserved_field_one, reserved_field_two, lane_zero_checksum_value, lane_deskew_enable;
    logic [7:0]  disparity_irq, invalid_symbol_irq;
    logic [4:0]  control_words_per_frame;
    logic        reg_rd_valid, high_density_flag;
    int          fail_count = 0;
    int          n_compared = 0;
    int          cycles = 0;

    always #4 clk = ~clk;

    lane_err_monitor u_lane_err_monitor (.clk(clk), .rstn(rstn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
        .disparity_err(disparity_err), .invalid_symbol_err(invalid_symbol_err),
        .unexpected_ctrl_err(unexpected_ctrl_err), .error_threshold(error_threshold),
        .checksum_load(checksum_load), .checksum_calc(checksum_calc), .high_density_flag(high_density_flag),
        .control_words_per_frame(control_words_per_frame), .reserved_field_one(reserved_field_one),
        .reserved_field_two(reserved_field_two), .lane_zero_checksum_value(lane_zero_checksum_value),
        .lane_deskew_enable(lane_deskew_enable), .disparity_irq(disparity_irq),
        .invalid_symbol_irq(invalid_symbol_irq));
    link_tx_model u_link_tx_model (.clk(clk), .disparity_err(disparity_err),
        .invalid_symbol_err(invalid_symbol_err), .unexpected_ctrl_err(unexpected_ctrl_err));

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wr_data = d;
        @(posedge clk) #1;
        reg_wr_en = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk) #1;
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(posedge clk) #1;
        reg_rd_en = 1'b0;
        check({7'h00, reg_rd_valid}, 8'h01);
        check(reg_rd_data, exp);
    endtask
    task automatic t_reset;
        check({high_density_flag, 2'b00, control_words_per_frame}, 8'h80);
        rd(12'h45a, 8'h80);
        rd(12'h45b, 8'h00);
        rd(12'h45c, 8'h00);
        rd(12'h45d, 8'h45);
        rd(12'h46c, 8'h0f);
        rd(12'h46e, 8'h00);
        rd(12'h460, 8'h00);
    endtask
    task automatic t_config;
        wr(12'h45a, 8'h00);
        check({high_density_flag, 2'b00, control_words_per_frame}, 8'h00);
        wr(12'h45a, 8'he0);
        rd(12'h45a, 8'h80);
        wr(12'h45b, 8'h3c);
        rd(12'h45b, 8'h3c);
        check(reserved_field_one, 8'h3c);
        wr(12'h45c, 8'hc3);
        check(reserved_field_two, 8'hc3);
        wr(12'h45d, 8'ha5);
        check(lane_zero_checksum_value, 8'ha5);
        checksum_calc = 8'h12;
        checksum_load = 1'b1;
        @(posedge clk) #1;
        checksum_load = 1'b0;
        rd(12'h45d, 8'h12);
        wr(12'h46c, 8'hf0);
        check(lane_deskew_enable, 8'hf0);
    endtask
    task automatic t_count;
        u_link_tx_model.burst(2'b00, 3'd5, 3);
        wr(12'h46b, 8'h50);
        rd(12'h46b, 8'h03);
        rd(12'h46d, 8'h20);
        check(disparity_irq, 8'h20);
        u_link_tx_model.burst(2'b01, 3'd2, 2);
        wr(12'h46b, 8'h21);
        rd(12'h46b, 8'h02);
        rd(12'h46e, 8'h00);
        u_link_tx_model.burst(2'b01, 3'd2, 1);
        rd(12'h46e, 8'h04);
        check(invalid_symbol_irq, 8'h04);
        u_link_tx_model.burst(2'b10, 3'd7, 4);
        wr(12'h46b, 8'h72);
        rd(12'h46b, 8'h04);
        wr(12'h46b, 8'h73);
        rd(12'h46b, 8'h00);
    endtask
    // Flag of the lane is the only one set when this runs
    task automatic t_ctrl(input logic [11:0] a, input logic [1:0] kind, input logic [2:0] lane);
        logic [7:0] flag_v;
        flag_v = 8'h01 << lane;
        wr(a, {5'b10000, lane});
        check(kind == 2'b00 ? disparity_irq : invalid_symbol_irq, 8'h00);
        rd(a, flag_v);
        wr(a, {5'b01000, lane});
        u_link_tx_model.burst(kind, lane, 2);
        wr(12'h46b, {1'b0, lane, 2'b00, kind});
        rd(12'h46b, 8'h03);
        wr(a, {5'b00100, lane});
        rd(12'h46b, 8'h00);
        rd(a, 8'h00);
        u_link_tx_model.burst(kind, lane, 1);
        rd(12'h46b, 8'h01);
    endtask
    // Lane 5 disparity and lane 2 invalid symbol each hold a count of one here
    task automatic t_threshold;
        error_threshold = 8'h01;
        rd(12'h46d, 8'h20);
        rd(12'h46e, 8'h04);
        error_threshold = 8'h00;
        wr(12'h46d, 8'h25);
        u_link_tx_model.burst(2'b00, 3'd5, 2);
        rd(12'h46d, 8'h00);
        rd(12'h46e, 8'h04);
        wr(12'h46b, 8'h50);
        rd(12'h46b, 8'h02);
        check(disparity_irq, 8'h20);
        check(invalid_symbol_irq, 8'h04);
        error_threshold = 8'h03;
    endtask
    // One error more than the counter can hold
    task automatic t_saturate;
        u_link_tx_model.burst(2'b10, 3'd0, 256);
        wr(12'h46b, 8'h02);
        rd(12'h46b, 8'hff);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_reset;
        t_config;
        t_count;
        t_ctrl(12'h46d, 2'b00, 3'd5);
        t_ctrl(12'h46e, 2'b01, 3'd2);
        t_threshold;
        t_saturate;
        results;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            results;
        end
    end
endmodule // lane_err_monitor_test
`default_nettype wire
